// >>> core/irt_avmm_slave.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Avalon-MM front end: one wait cycle, then a single-cycle completion
module irt_avmm_slave
   import irt_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [DATA_W-1:0] rd_word,
   output logic                   avs_waitrequest,
   output logic [DATA_W-1:0]      avs_readdata,
   output logic                   acc_done
);

   irt_bus_e          state_r;      // Handshake state
   irt_bus_e          state_nxt;
   logic [DATA_W-1:0] rdata_r;      // Captured read word
   logic [DATA_W-1:0] rdata_nxt;
   logic              req;          // Any request pending

   assign req = avs_read | avs_write;

   ////////////////////////////////////////////////////////////////////////
   // Next state; the read word is caught in the wait cycle so that it
   // stands steady at the completing edge
   always_comb
   begin
      state_nxt = state_r;
      rdata_nxt = rdata_r;
      case (state_r)
         BUS_IDLE:
         begin
            // Request seen: capture and complete next cycle
            if (req)
            begin
               state_nxt = BUS_DONE;
               if (avs_read)
                  rdata_nxt = rd_word;
            end
         end
         default:
         begin
            // Completion cycle always returns to idle
            state_nxt = BUS_IDLE;
         end
      endcase
   end

   // Register only
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= BUS_IDLE;
         rdata_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Waitrequest stays high except in the completion cycle
   assign avs_waitrequest = (state_r != BUS_DONE);
   assign avs_readdata    = rdata_r;
   assign acc_done        = (state_r == BUS_DONE) & req;

endmodule : irt_avmm_slave

`default_nettype wire

// >>> core/irt_pkg.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Shared constants and types for the interrupt routing enables
package irt_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W   = 8;          // Byte address width
   localparam int unsigned DATA_W   = 32;         // Bus data width
   localparam int unsigned BE_W     = 4;          // Byte enable width
   localparam int unsigned IDX_W    = 6;          // Register index width
   localparam int unsigned SLOT_N   = 12;         // Time slots A to L
   localparam int unsigned DSLOT_N  = 4;          // Data slots A to D
   localparam int unsigned REG_W    = 16;         // Register width
   localparam int unsigned EVT_N    = 3;          // Event status bits

   // Register indexes; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_Y_DATA_EN  = 6'h15;
   localparam logic [IDX_W-1:0] IDX_X_LEV0_EN  = 6'h16;
   localparam logic [IDX_W-1:0] IDX_X_LEV1_EN  = 6'h17;
   localparam logic [IDX_W-1:0] IDX_X_CMP1_EN  = 6'h18;
   localparam logic [IDX_W-1:0] IDX_X_CMP2_EN  = 6'h19;
   localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 6'h20;
   localparam logic [IDX_W-1:0] IDX_EVT_MASK   = 6'h21;
   localparam logic [IDX_W-1:0] IDX_LIVE_STATE = 6'h22;

   // Field layout
   localparam int unsigned SLOT_LSB   = 0;        // Slot A sits at bit 0
   localparam int unsigned SLOT_MSB   = 11;       // Slot L sits at bit 11
   localparam int unsigned DSLOT_MSB  = 3;        // Slot D sits at bit 3
   localparam int unsigned EVT_X_BIT  = 0;        // First output rose
   localparam int unsigned EVT_Y_BIT  = 1;        // Second output rose
   localparam int unsigned EVT_BAD    = 2;        // Unmapped access

   // Reset values
   localparam logic [SLOT_N-1:0]  SLOT_EN_RST  = 12'h000;
   localparam logic [DSLOT_N-1:0] DSLOT_EN_RST = 4'h0;
   localparam logic [EVT_N-1:0]   EVT_RST      = 3'h0;

   // Status flags raised by the measurement sequencer
   typedef struct packed {
      logic [SLOT_N-1:0]  level_zero_status;
      logic [SLOT_N-1:0]  level_one_status;
      logic [SLOT_N-1:0]  compare_class_one_status;
      logic [SLOT_N-1:0]  compare_class_two_status;
      logic [DSLOT_N-1:0] slot_data_status;
   } irt_status_s;

   // Routing enables as held by the register bank
   typedef struct packed {
      logic [SLOT_N-1:0]  lev0;
      logic [SLOT_N-1:0]  lev1;
      logic [SLOT_N-1:0]  cmp1;
      logic [SLOT_N-1:0]  cmp2;
      logic [DSLOT_N-1:0] ydata;
   } irt_enable_s;

   // Bus slave handshake state
   typedef enum logic {
      BUS_IDLE,
      BUS_DONE
   } irt_bus_e;

endpackage : irt_pkg

`default_nettype wire

// >>> core/irt_route.sv
// Chosen here: the Avalon-MM interface to the registers.
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Interrupt routing enables with Avalon-MM register access
// Four slot-class enable words feed the first output, one data-enable
// word feeds the second; a third line summarises own events
module irt_route
   import irt_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [DATA_W-1:0] avs_writedata,
   input  wire logic [BE_W-1:0]   avs_byteenable,
   output logic [DATA_W-1:0]      avs_readdata,
   output logic                   avs_waitrequest,
   input  wire irt_status_s       status_in,
   output logic                   irq_x,
   output logic                   irq_y,
   output logic                   irq_evt
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // True when a byte address selects the register at an index.
   // Registers sit on word boundaries, so the two low address bits
   // must be zero; a byte-offset access counts as unmapped.
   function automatic logic addr_hit(
      input logic [ADDR_W-1:0] addr,
      input logic [IDX_W-1:0]  idx
   );
      addr_hit = (addr == {idx, 2'b00});
   endfunction : addr_hit

   // Merge write data into a 16-bit register by byte lanes
   // Lanes 2 and 3 carry nothing; the upper half always reads zero
   function automatic logic [REG_W-1:0] lane_merge(
      input logic [REG_W-1:0]  cur,
      input logic [DATA_W-1:0] wd,
      input logic [BE_W-1:0]   be
   );
      logic [REG_W-1:0] v;
      v = cur;
      if (be[0])
         v[7:0] = wd[7:0];
      if (be[1])
         v[15:8] = wd[15:8];
      lane_merge = v;
   endfunction : lane_merge

   // Gate a slot vector by its enable and fold it to one bit
   // Shared by all four slot classes of the first output
   function automatic logic gate_any(
      input logic [SLOT_N-1:0] st,
      input logic [SLOT_N-1:0] en
   );
      gate_any = |(st & en);
   endfunction : gate_any

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   // Enables are kept as one struct so the reset and the register stage
   // stay in step across all five fields

   irt_enable_s       en_r;         // Routing enables
   irt_enable_s       en_nxt;
   logic [EVT_N-1:0]  evt_r;        // Sticky event bits
   logic [EVT_N-1:0]  evt_nxt;
   logic [EVT_N-1:0]  mask_r;       // Event mask
   logic [EVT_N-1:0]  mask_nxt;
   logic              irq_x_r;      // Routed first output
   logic              irq_x_nxt;
   logic              irq_y_r;      // Routed second output
   logic              irq_y_nxt;
   logic              irq_evt_r;    // Masked event output
   logic              irq_evt_nxt;

   logic              acc_done;     // Bus access completes now
   logic              wr_fire;      // Write takes effect now
   logic [DATA_W-1:0] rd_word;      // Decoded read value
   logic              mapped;       // Address hits a register
   logic [REG_W-1:0]  wmerged;      // Merge scratch for all five enable fields
   logic [EVT_N-1:0]  evt_set;      // Events raised this cycle
   logic [EVT_N-1:0]  evt_clr;      // Write-one-to-clear bits

   assign wr_fire = acc_done & avs_write;

   ////////////////////////////////////////////////////////////////////////
   // Bus front end
   // The slave inserts one wait cycle on every access; the read word is
   // caught in that cycle, so a read sees enables as they stood one
   // edge before completion
   irt_avmm_slave u_bus (
      .clk             (clk),
      .rst             (rst),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .rd_word         (rd_word),
      .avs_waitrequest (avs_waitrequest),
      .avs_readdata    (avs_readdata),
      .acc_done        (acc_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read decode; reserved and unused bits read as zero
   // Address decode is a priority chain; the indexes never overlap so
   // the order matters only for timing
   always_comb
   begin
      rd_word = '0;
      mapped  = 1'b1;
      if (addr_hit(avs_address, IDX_Y_DATA_EN))
         rd_word[DSLOT_MSB:SLOT_LSB] = en_r.ydata;
      else if (addr_hit(avs_address, IDX_X_LEV0_EN))
         rd_word[SLOT_MSB:SLOT_LSB] = en_r.lev0;
      else if (addr_hit(avs_address, IDX_X_LEV1_EN))
         rd_word[SLOT_MSB:SLOT_LSB] = en_r.lev1;
      else if (addr_hit(avs_address, IDX_X_CMP1_EN))
         rd_word[SLOT_MSB:SLOT_LSB] = en_r.cmp1;
      else if (addr_hit(avs_address, IDX_X_CMP2_EN))
         rd_word[SLOT_MSB:SLOT_LSB] = en_r.cmp2;
      else if (addr_hit(avs_address, IDX_EVT_STATUS))
         rd_word[EVT_N-1:0] = evt_r;
      else if (addr_hit(avs_address, IDX_EVT_MASK))
         rd_word[EVT_N-1:0] = mask_r;
      else if (addr_hit(avs_address, IDX_LIVE_STATE))
      begin
         // Live view of the routed outputs
         // Lets software poll without enabling the summary line
         rd_word[EVT_X_BIT] = irq_x_r;
         rd_word[EVT_Y_BIT] = irq_y_r;
      end
      else
      begin
         // Unmapped: reads zero, writes dropped
         mapped = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Enable registers; only the documented field bits are stored so
   // reserved bits can never be set by software
   // A partial write merges by byte lane so a single lane keeps the
   // other lane's enables
   always_comb
   begin
      en_nxt  = en_r;
      wmerged = '0;
      if (wr_fire)
      begin
         if (addr_hit(avs_address, IDX_Y_DATA_EN))
         begin
            wmerged = lane_merge({12'h000, en_r.ydata},
                                 avs_writedata, avs_byteenable);
            en_nxt.ydata = wmerged[DSLOT_MSB:SLOT_LSB];
         end
         else if (addr_hit(avs_address, IDX_X_LEV0_EN))
         begin
            wmerged = lane_merge({4'h0, en_r.lev0},
                                 avs_writedata, avs_byteenable);
            en_nxt.lev0 = wmerged[SLOT_MSB:SLOT_LSB];
         end
         else if (addr_hit(avs_address, IDX_X_LEV1_EN))
         begin
            wmerged = lane_merge({4'h0, en_r.lev1},
                                 avs_writedata, avs_byteenable);
            en_nxt.lev1 = wmerged[SLOT_MSB:SLOT_LSB];
         end
         else if (addr_hit(avs_address, IDX_X_CMP1_EN))
         begin
            wmerged = lane_merge({4'h0, en_r.cmp1},
                                 avs_writedata, avs_byteenable);
            en_nxt.cmp1 = wmerged[SLOT_MSB:SLOT_LSB];
         end
         else if (addr_hit(avs_address, IDX_X_CMP2_EN))
         begin
            wmerged = lane_merge({4'h0, en_r.cmp2},
                                 avs_writedata, avs_byteenable);
            en_nxt.cmp2 = wmerged[SLOT_MSB:SLOT_LSB];
         end
         else
         begin
            // Other addresses leave the enables alone
            wmerged = '0;
         end
      end
   end

   // Register only; all enables clear at reset
   // Nothing is routed until software sets an enable
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         en_r.lev0  <= SLOT_EN_RST;
         en_r.lev1  <= SLOT_EN_RST;
         en_r.cmp1  <= SLOT_EN_RST;
         en_r.cmp2  <= SLOT_EN_RST;
         en_r.ydata <= DSLOT_EN_RST;
      end
      else
      begin
         en_r <= en_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Routing; outputs are registered so they never glitch on the pin,
   // at the cost of one cycle from status to output
   // The status flags come from logic on this clock, so no
   // synchroniser is needed; a flag that pulses for one cycle still
   // reaches the output for one cycle
   always_comb
   begin
      irq_x_nxt =
         gate_any(status_in.level_zero_status, en_r.lev0) |
         gate_any(status_in.level_one_status, en_r.lev1) |
         gate_any(status_in.compare_class_one_status,
                  en_r.cmp1) |
         gate_any(status_in.compare_class_two_status,
                  en_r.cmp2);
      irq_y_nxt =
         |(status_in.slot_data_status & en_r.ydata);
   end

   // Register only
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq_x_r <= 1'b0;
         irq_y_r <= 1'b0;
      end
      else
      begin
         irq_x_r <= irq_x_nxt;
         irq_y_r <= irq_y_nxt;
      end
   end

   // Outputs straight from the flops
   assign irq_x = irq_x_r;
   assign irq_y = irq_y_r;

   ////////////////////////////////////////////////////////////////////////
   // Event status, mask and summary interrupt
   // Events are own bookkeeping next to the routing: a rising routed
   // output or an unmapped access leaves a sticky bit that software
   // clears by writing a one
   always_comb
   begin
      // Rising edges of the routed outputs and bad accesses
      // Edges use the next value so the event lands with the output
      evt_set            = '0;
      evt_set[EVT_X_BIT] = irq_x_nxt & ~irq_x_r;
      evt_set[EVT_Y_BIT] = irq_y_nxt & ~irq_y_r;
      evt_set[EVT_BAD]   = acc_done & ~mapped;
      // Write one to clear, low byte only
      // Upper bits of the word are ignored
      evt_clr = '0;
      if (wr_fire && avs_byteenable[0] &&
          addr_hit(avs_address, IDX_EVT_STATUS))
         evt_clr = avs_writedata[EVT_N-1:0];
      // A set in the clearing cycle wins so no event is lost
      evt_nxt  = (evt_r & ~evt_clr) | evt_set;
      // Mask is plain read-write, low byte only
      mask_nxt = mask_r;
      if (wr_fire && avs_byteenable[0] &&
          addr_hit(avs_address, IDX_EVT_MASK))
         mask_nxt = avs_writedata[EVT_N-1:0];
      irq_evt_nxt = |(evt_nxt & mask_nxt);
   end

   // Register only
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         evt_r     <= EVT_RST;
         mask_r    <= EVT_RST;
         irq_evt_r <= 1'b0;
      end
      else
      begin
         evt_r     <= evt_nxt;
         mask_r    <= mask_nxt;
         irq_evt_r <= irq_evt_nxt;
      end
   end

   // Summary line; next values are used so it tracks a clearing write
   assign irq_evt = irq_evt_r;

endmodule : irt_route

`default_nettype wire

// >>> tb/irt_monitor.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Port checks of the routing enables
module irt_monitor
   import irt_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [DATA_W-1:0] avs_readdata,
   input wire logic              avs_waitrequest,
   input wire irt_status_s       status_in,
   input wire logic              irq_x,
   input wire logic              irq_y
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic x_src;   // Any class flag up
   logic y_src;   // Any data flag up
   logic wr_done; // Write lands this edge
   assign x_src   = |status_in[4+:48];
   assign y_src   = |status_in.slot_data_status;
   assign wr_done = avs_write && !avs_waitrequest;

   ////////////////////////////////////////////////////////////////////////
   // Named steps
   sequence s_req;
      $rose(avs_read || avs_write);
   endsequence
   sequence s_quiet;
      !irq_x && !irq_y;
   endsequence

   property p_wait_cycle;
      s_req |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   property p_rst_quiet;
      $fell(rst) |-> s_quiet [*3];
   endproperty
   property p_x_cause;
      irq_x |-> $past(x_src);
   endproperty
   property p_x_idle;
      !x_src |=> !irq_x;
   endproperty
   property p_y_cause;
      irq_y |-> $past(y_src);
   endproperty
   // Enables move on a landed write and reach irq one edge later
   property p_x_hold;
      !wr_done && !$past(wr_done) && $stable(status_in) |=> $stable(irq_x);
   endproperty
   property p_y_hold;
      !wr_done && !$past(wr_done) && $stable(status_in) |=> $stable(irq_y);
   endproperty
   property p_rd_resv;
      avs_read && !avs_waitrequest |-> avs_readdata[31:12] == 20'h00000;
   endproperty

   a_wait_cycle: assert property (p_wait_cycle)
      else $error("request not answered after one wait");
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("interrupt up right after reset");
   a_x_cause: assert property (p_x_cause)
      else $error("irq_x with no flag");
   a_x_idle: assert property (p_x_idle)
      else $error("irq_x stays up with flags clear");
   a_y_cause: assert property (p_y_cause)
      else $error("irq_y with no flag");
   a_x_hold: assert property (p_x_hold)
      else $error("irq_x moved without cause");
   a_y_hold: assert property (p_y_hold)
      else $error("irq_y moved without cause");
   a_rd_resv: assert property (p_rd_resv)
      else $error("reserved read bits set");
endmodule : irt_monitor

`default_nettype wire

// >>> tb/irt_route_tb_top.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Self-checking bench of the routing enables
module irt_route_tb_top
   import irt_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic              clk;
   logic              rst;
   logic [ADDR_W-1:0] avs_address;
   logic              avs_read;
   logic              avs_write;
   logic [DATA_W-1:0] avs_writedata;
   logic [BE_W-1:0]   avs_byteenable;
   logic [DATA_W-1:0] avs_readdata;
   logic              avs_waitrequest;
   irt_status_s       pat;       // Flags asked of the model
   irt_status_s       status_in; // Flags as driven
   logic              irq_x;
   logic              irq_y;
   logic              irq_evt;
   int                en_m [5];  // Reference enables, 0x15..0x19
   int                n_errors;
   int                checks;
   logic [31:0]       rng;       // Xorshift state
   logic [31:0]       q;         // Last read word

   irt_route dut (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .status_in(status_in), .irq_x(irq_x), .irq_y(irq_y),
      .irq_evt(irq_evt));
   irt_seq_model u_seq (.clk(clk), .rst(rst), .pat(pat),
      .status_in(status_in));

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : rnd
   // Expected outputs: OR of flags whose enable is set
   function automatic logic ex_x();
      return |(pat.level_zero_status & en_m[1][11:0])
         | |(pat.level_one_status & en_m[2][11:0])
         | |(pat.compare_class_one_status & en_m[3][11:0])
         | |(pat.compare_class_two_status & en_m[4][11:0]);
   endfunction : ex_x
   function automatic logic ex_y();
      return |(pat.slot_data_status & en_m[0][3:0]);
   endfunction : ex_y
   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %0t: word %h want %h", $time, got, exp);
      end
   endtask : chk_w
   task automatic chk_b(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %0t: line %b want %b", $time, got, exp);
      end
   endtask : chk_b
   // One bus cycle; held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      avs_write      <= wr;
      avs_read       <= !wr;
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      // No fixed latency assumed; only the watchdog ends a hung wait
      do
      begin
         @(posedge clk);
      end
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk);
   endtask : bus
   // Write an enable and track it; reserved bits never stick
   task automatic mwr(input int i, input logic [31:0] d,
                      input logic [3:0] be);
      logic [31:0] m;
      m = {16'h0000, {8{be[1]}}, {8{be[0]}}};
      en_m[i] = ((en_m[i] & ~m) | (d & m)) & (i == 0 ? 32'hf : 32'hfff);
      bus(1'b1, 8'h54 + 8'(i * 4), d, be);
   endtask : mwr
   task automatic close_out();
      $display("n_errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////
   // Clock and watchdog, a few hundred cycles expected
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      #400000;
      n_errors++;
      close_out();
   end

   // Main sequence
   initial
   begin
      {rst, avs_read, avs_write} = 3'h4;
      {avs_address, avs_writedata, avs_byteenable} = '0;
      pat = '0;
      rng = 32'h0000003d;
      en_m = '{default: 0};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 5; i++)
      begin
         bus(1'b0, 8'h54 + 8'(i * 4), '0, 4'hf);
         chk_w(q, 32'h0);
         mwr(i, 32'hffffffff, 4'hf);
         bus(1'b0, 8'h54 + 8'(i * 4), '0, 4'hf);
         chk_w(q, en_m[i]);
      end
      // Low lane only, then an unmapped place
      mwr(1, 32'h0, 4'h1);
      bus(1'b0, 8'h58, '0, 4'hf);
      chk_w(q, en_m[1]);
      bus(1'b0, 8'h00, '0, 4'hf);
      chk_w(q, 32'h0);
      // Sparse random flags and enables
      repeat (60)
      begin
         mwr(rnd() % 5, rnd() & rnd() & rnd(), 4'hf);
         pat <= irt_status_s'({rnd(), rnd()} & {rnd(), rnd()}
            & {rnd(), rnd()});
         repeat (3) @(posedge clk);
         chk_b(irq_x, ex_x());
         chk_b(irq_y, ex_y());
      end
      // Reset mid-run with every flag up
      pat <= '1;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      en_m = '{default: 0};
      repeat (3) @(posedge clk);
      chk_b(irq_x | irq_y, 1'b0);
      mwr(4, 32'h800, 4'hf);
      mwr(0, 32'h1, 4'hf);
      // The new enable reaches the output one edge after the write lands
      @(posedge clk);
      chk_b(irq_x & irq_y, 1'b1);
      bus(1'b0, 8'h88, '0, 4'hf);
      chk_w(q, 32'h3);
      bus(1'b0, 8'h80, '0, 4'hf);
      chk_w(q, 32'h3);
      // Sticky events, mask and summary line
      bus(1'b1, 8'h80, 32'h7, 4'hf);
      bus(1'b1, 8'h84, 32'h4, 4'hf);
      bus(1'b0, 8'h00, '0, 4'hf);
      chk_b(irq_evt, 1'b1);
      bus(1'b1, 8'h84, 32'h0, 4'hf);
      chk_b(irq_evt, 1'b0);
      bus(1'b1, 8'h84, 32'h4, 4'hf);
      bus(1'b1, 8'h80, 32'h4, 4'hf);
      chk_b(irq_evt, 1'b0);
      close_out();
   end
endmodule : irt_route_tb_top

bind irt_route irt_monitor u_mon (.clk(clk), .rst(rst),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .status_in(status_in), .irq_x(irq_x), .irq_y(irq_y));

`default_nettype wire

// >>> tb/irt_seq_model.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Sequencer stand-in: flags move only on the clock, clear in reset
module irt_seq_model
   import irt_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire irt_status_s pat,
   output var irt_status_s  status_in
);
   // Register the requested flags; level, no handshake
   always_ff @(posedge clk or posedge rst)
      if (rst)
         status_in <= '0;
      else
         status_in <= pat;
endmodule : irt_seq_model

`default_nettype wire
